/* File: spi_port_control_config.sv */
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
module spi_port_control_config
   import spi_port_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [2:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   output logic [7:0] rdata_o,
   input wire logic tmr_tick_i,
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe_n_o,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic sdo_oe_n_o,
   input wire logic sel_n_i,
   output logic irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and state.

   pins_s sync1_r, sync2_r;
   logic sck_d_r;
   ctl_s ctl_r;
   logic [7:0] transfer_buffer, serial_shift_reg;
   logic buffer_full_flag, busy_r, phase_r, phase_nxt, in_bit_r;
   logic [3:0] cnt_r;
   logic [5:0] div_r;
   logic [EVT_W-1:0] evt_r, mask_r, evt_nxt;
   logic [7:0] rdata_r;
   logic sck_r, sck_oe_n_r, sdo_r, sdo_oe_n_r, irq_r;

   // Half period of the master bit clock in core clocks.
   function automatic logic [5:0] half_of(input logic [3:0] mode);
      case (mode)
         MODE_M_DIV4: half_of = HALF_FAST;
         MODE_M_DIV16: half_of = HALF_MID;
         default: half_of = HALF_SLOW;
      endcase
   endfunction

   // Two flops before any logic looks at a pin.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync1_r <= '1;
         sync2_r <= '1;
         sck_d_r <= 1'b0;
      end else begin
         sync1_r <= '{sck: sck_i, sdi: sdi_i, sel_n: sel_n_i};
         sync2_r <= sync1_r;
         sck_d_r <= sync2_r.sck;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode and shift strobes.

   logic master_w, slave_w, sel_ok_w, kill_w, tick_w, act_w, act_d_w;
   logic lead_w, trail_w, done_w, busy_any_w, buf_wr_w, wr_ok_w, collide_w;
   logic rd_buf_w, bf_eff_w;
   logic [7:0] rx_byte_w;

   // Reserved codes leave the port idle, exactly like a cleared enable.
   assign master_w = ctl_r.port_enable_bit && (ctl_r.port_mode_select <= MODE_M_TMR);
   assign slave_w = ctl_r.port_enable_bit &&
                    (ctl_r.port_mode_select == MODE_S_SEL || ctl_r.port_mode_select == MODE_S_FREE);
   assign sel_ok_w = (ctl_r.port_mode_select == MODE_S_FREE) || !sync2_r.sel_n;
   assign kill_w = !(master_w || slave_w) || (slave_w && !sel_ok_w);
   assign tick_w = (ctl_r.port_mode_select == MODE_M_TMR) ? tmr_tick_i
                 : (div_r == half_of(ctl_r.port_mode_select) - 6'h01);
   assign act_w = sync2_r.sck ^ ctl_r.clock_idle_polarity;
   assign act_d_w = sck_d_r ^ ctl_r.clock_idle_polarity;
   assign lead_w = (master_w && busy_r && tick_w && !phase_r) || (slave_w && sel_ok_w && act_w && !act_d_w);
   assign trail_w = (master_w && busy_r && tick_w && phase_r) || (slave_w && sel_ok_w && !act_w && act_d_w);
   assign done_w = trail_w && (cnt_r == BYTE_BITS - 4'h1);
   assign rx_byte_w = {serial_shift_reg[6:0], master_w ? sync2_r.sdi : in_bit_r};
   assign busy_any_w = master_w ? busy_r : (cnt_r != 4'h0 || phase_r);
   assign buf_wr_w = we_i && addr_i == OFS_BUF;
   assign wr_ok_w = buf_wr_w && (master_w || slave_w) && !busy_any_w;
   assign collide_w = buf_wr_w && ctl_r.port_enable_bit && busy_any_w;
   assign rd_buf_w = re_i && addr_i == OFS_BUF;
   assign bf_eff_w = buffer_full_flag && !rd_buf_w;

   // Phase is high while the clock sits at its active level.
   always_comb begin
      phase_nxt = phase_r;
      if (kill_w || wr_ok_w) begin
         phase_nxt = 1'b0;
      end else if (lead_w) begin
         phase_nxt = 1'b1;
      end else if (trail_w) begin
         phase_nxt = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shifter: sdi lags two cycles, a whole fast half period, so a master takes its bit at the trailing edge.

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         serial_shift_reg <= 8'h00;
         cnt_r <= 4'h0;
         busy_r <= 1'b0;
         phase_r <= 1'b0;
         in_bit_r <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
         if (kill_w) begin
            cnt_r <= 4'h0;
            busy_r <= 1'b0;
         end else if (wr_ok_w) begin
            serial_shift_reg <= wdata_i;
            cnt_r <= 4'h0;
            busy_r <= master_w;
         end else begin
            if (lead_w) begin
               in_bit_r <= sync2_r.sdi;
            end
            if (trail_w) begin
               serial_shift_reg <= rx_byte_w;
               cnt_r <= done_w ? 4'h0 : cnt_r + 4'h1;
               if (done_w) begin
                  busy_r <= 1'b0;
               end
            end
         end
      end
   end

   // Divider restarts with every transfer so the first edge is a full half period away.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_r <= 6'h00;
      end else if (!busy_r || tick_w) begin
         div_r <= 6'h00;
      end else begin
         div_r <= div_r + 6'h01;
      end
   end

   // Pin drivers; the clock rests at the idle polarity whenever phase is low.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sck_r <= 1'b0;
         sck_oe_n_r <= 1'b1;
         sdo_r <= 1'b0;
         sdo_oe_n_r <= 1'b1;
      end else begin
         sck_r <= ctl_r.clock_idle_polarity ^ phase_nxt;
         sck_oe_n_r <= !master_w;
         sdo_oe_n_r <= !(master_w || (slave_w && sel_ok_w));
         if (wr_ok_w) begin
            sdo_r <= wdata_i[7];
         end else if (trail_w) begin
            sdo_r <= serial_shift_reg[6];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Buffer, control, events and register reads.

   // A slave that finishes a byte while the old one is unread loses the new byte; a master overwrites.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         transfer_buffer <= BUF_RESET;
         buffer_full_flag <= 1'b0;
      end else begin
         if (wr_ok_w) begin
            transfer_buffer <= wdata_i;
         end
         if (done_w && (!bf_eff_w || master_w)) begin
            transfer_buffer <= rx_byte_w;
            buffer_full_flag <= 1'b1;
         end else if (rd_buf_w) begin
            buffer_full_flag <= 1'b0;
         end
      end
   end

   // Hardware setting of the two flags wins over a software write in the same cycle.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctl_r <= CTL_RESET;
      end else begin
         if (we_i && addr_i == OFS_CTL) begin
            ctl_r <= wdata_i;
         end
         if (collide_w) begin
            ctl_r.write_collision_flag <= 1'b1;
         end
         if (done_w && bf_eff_w && slave_w) begin
            ctl_r.receive_overflow_flag <= 1'b1;
         end
      end
   end

   // Sticky events, cleared by reading them; a new event in the read cycle survives.
   always_comb begin
      evt_nxt = (re_i && addr_i == OFS_EVT) ? EVT_RESET : evt_r;
      evt_nxt[EVT_RX_BIT] = evt_nxt[EVT_RX_BIT] | done_w;
      evt_nxt[EVT_WRITE_COLLISION_FLAG_BIT] = evt_nxt[EVT_WRITE_COLLISION_FLAG_BIT] | collide_w;
      evt_nxt[EVT_OVF_BIT] = evt_nxt[EVT_OVF_BIT] | (done_w && bf_eff_w && slave_w);
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         evt_r <= EVT_RESET;
         mask_r <= EVT_RESET;
         irq_r <= 1'b0;
      end else begin
         evt_r <= evt_nxt;
         if (we_i && addr_i == OFS_MASK) begin
            mask_r <= wdata_i[EVT_W-1:0];
         end
         irq_r <= |(evt_nxt & mask_r);
      end
   end

   // Read data stand in the cycle after the strobe; unmapped indexes read zero.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_r <= 8'h00;
      end else if (re_i) begin
         case (addr_i)
            OFS_CTL: rdata_r <= ctl_r;
            OFS_BUF: rdata_r <= transfer_buffer;
            OFS_STAT: rdata_r <= 8'(buffer_full_flag) << STAT_BF_BIT;
            OFS_EVT: rdata_r <= {5'h00, evt_r};
            OFS_MASK: rdata_r <= {5'h00, mask_r};
            default: rdata_r <= 8'h00;
         endcase
      end else begin
         rdata_r <= 8'h00;
      end
   end

   assign rdata_o = rdata_r;
   assign sck_o = sck_r;
   assign sck_oe_n_o = sck_oe_n_r;
   assign sdo_o = sdo_r;
   assign sdo_oe_n_o = sdo_oe_n_r;
   assign irq_o = irq_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   chk_idle_high_clock: assert property (@(posedge clk_i) disable iff (rst_i)
      (master_w && ctl_r.clock_idle_polarity && !busy_r && !phase_r) |=> sck_o)
      else $error("clock not high at idle");
   chk_idle_low_clock: assert property (@(posedge clk_i) disable iff (rst_i)
      (master_w && !ctl_r.clock_idle_polarity && !busy_r && !phase_r) |=> (!sck_o && !sck_oe_n_o))
      else $error("clock not driven low at idle");
   chk_free_slave_drive: assert property (@(posedge clk_i) disable iff (rst_i)
      (ctl_r.port_enable_bit && ctl_r.port_mode_select == MODE_S_FREE) |=> (!sdo_oe_n_o && sck_oe_n_o))
      else $error("free slave not driving data");
   chk_select_gates_out: assert property (@(posedge clk_i) disable iff (rst_i)
      (slave_w && ctl_r.port_mode_select == MODE_S_SEL && !sync2_r.sel_n) |=> !sdo_oe_n_o)
      else $error("selected slave not driving data");
   chk_timer_half_clock: assert property (@(posedge clk_i) disable iff (rst_i)
      (master_w && ctl_r.port_mode_select == MODE_M_TMR && busy_r && !phase_r && tmr_tick_i)
      |=> (sck_o != ctl_r.clock_idle_polarity))
      else $error("timer tick did not toggle clock");
   chk_slow_first_edge: assert property (@(posedge clk_i) disable iff (rst_i)
      ($rose(busy_r) && master_w && ctl_r.port_mode_select == MODE_M_DIV64)
      |-> ##31 (sck_o == ctl_r.clock_idle_polarity) ##1 (sck_o != ctl_r.clock_idle_polarity))
      else $error("divide by 64 edge misplaced");
   chk_fast_first_edge: assert property (@(posedge clk_i) disable iff (rst_i)
      ($rose(busy_r) && master_w && ctl_r.port_mode_select == MODE_M_DIV4)
      |-> ##1 (sck_o == ctl_r.clock_idle_polarity) ##1 (sck_o != ctl_r.clock_idle_polarity))
      else $error("divide by 4 edge misplaced");
   chk_write_collision: assert property (@(posedge clk_i) disable iff (rst_i)
      (collide_w && !done_w) |=> (ctl_r.write_collision_flag && $stable(transfer_buffer)))
      else $error("collision not flagged or write taken");
   chk_byte_to_buffer: assert property (@(posedge clk_i) disable iff (rst_i)
      (done_w && !bf_eff_w) |=> (buffer_full_flag && evt_r[EVT_RX_BIT] && transfer_buffer == $past(rx_byte_w)))
      else $error("received byte not delivered");
   chk_select_reset: assert property (@(posedge clk_i) disable iff (rst_i)
      (slave_w && ctl_r.port_mode_select == MODE_S_SEL && sync2_r.sel_n) |=> (cnt_r == 4'h0 && sdo_oe_n_o))
      else $error("deselect did not reset port");

endmodule

/* File: spi_port_pkg.sv */
package spi_port_pkg;

   // Register indexes on the plain register port.
   localparam logic [2:0] OFS_CTL = 3'h0;
   localparam logic [2:0] OFS_BUF = 3'h1;
   localparam logic [2:0] OFS_STAT = 3'h2;
   localparam logic [2:0] OFS_EVT = 3'h3;
   localparam logic [2:0] OFS_MASK = 3'h4;

   // Reset values and field positions.
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] BUF_RESET = 8'h00;
   localparam int STAT_BF_BIT = 0;
   localparam int EVT_W = 3;
   localparam int EVT_RX_BIT = 0;
   localparam int EVT_WRITE_COLLISION_FLAG_BIT = 1;
   localparam int EVT_OVF_BIT = 2;
   localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;

   // Mode codes of the port_mode_select field.
   localparam logic [3:0] MODE_M_DIV4 = 4'h0;
   localparam logic [3:0] MODE_M_DIV16 = 4'h1;
   localparam logic [3:0] MODE_M_DIV64 = 4'h2;
   localparam logic [3:0] MODE_M_TMR = 4'h3;
   localparam logic [3:0] MODE_S_SEL = 4'h4;
   localparam logic [3:0] MODE_S_FREE = 4'h5;

   // Bit clock dividers; the half period in core clocks follows from them.
   localparam int OSC_DIV_FAST = 4;
   localparam int OSC_DIV_MID = 16;
   localparam int OSC_DIV_SLOW = 64;
   localparam int TMR_DIV = 2;
   localparam logic [5:0] HALF_FAST = 6'(OSC_DIV_FAST / 2);
   localparam logic [5:0] HALF_MID = 6'(OSC_DIV_MID / 2);
   localparam logic [5:0] HALF_SLOW = 6'(OSC_DIV_SLOW / 2);
   localparam logic [3:0] BYTE_BITS = 4'h8;

   // Layout of serial_port_control, bit 7 down to bit 0.
   typedef struct packed {
      logic write_collision_flag;
      logic receive_overflow_flag;
      logic port_enable_bit;
      logic clock_idle_polarity;
      logic [3:0] port_mode_select;
   } ctl_s;

   // Serial pins sampled from outside the clock domain.
   typedef struct packed {
      logic sck;
      logic sdi;
      logic sel_n;
   } pins_s;

endpackage

/* File: spi_far_model.sv */
`timescale 1ns/1ps
// Far-side serial device: it follows the port's clock when the port drives the pin, else it makes its own.
module spi_far_model (
   input wire logic clk_i,
   input wire logic pol_i,
   input wire logic start_i,
   input wire logic [7:0] tx_i,
   input wire logic sck_i,
   input wire logic sck_oe_n_i,
   input wire logic sdo_i,
   input wire logic sdo_oe_n_i,
   output logic sck_pin_o,
   output logic sdi_o = 1'b0,
   output logic [7:0] rx_o = 8'h00,
   output logic busy_o
);
   logic ph = 1'b0;
   logic last = 1'b0;
   logic lead_d = 1'b0;
   logic [7:0] sh = 8'h00;
   int cnt = 0;
   // A released data line shows the inverse of its last driven level, so a stale copy is never sampled.
   wire logic sdo_line = sdo_oe_n_i ? ~last : sdo_i;
   // Pin level from both parties; the own clock rests at the idle level of the polarity.
   assign sck_pin_o = sck_oe_n_i ? (pol_i ^ ph) : sck_i;
   assign busy_o = (cnt != 0);
   wire logic lead = sck_pin_o ^ pol_i;
   // One process owns every register, so clock edges are seen one core cycle late and never as glitches.
   always @(posedge clk_i) begin
      lead_d <= lead;
      if (!sdo_oe_n_i) last <= sdo_i;
      // Sample on the leading edge, first bit the top one.
      if (lead && !lead_d) rx_o <= {rx_o[6:0], sdo_line};
      if (start_i) begin
         sh <= tx_i;
         sdi_o <= tx_i[7];
         cnt <= sck_oe_n_i ? 128 : 0;
      end else begin
         // Facing a slave port, clock sixteen half periods of eight cycles.
         if (cnt != 0) begin
            cnt <= cnt - 1;
            if (cnt % 8 == 1) ph <= ~ph;
         end
         // Present the next bit on the trailing edge.
         if (!lead && lead_d) begin
            sdi_o <= sh[6];
            sh <= {sh[6:0], ~sh[7]};
         end
      end
   end
endmodule

/* File: spi_port_control_config_bench.sv */
`timescale 1ns/1ps
module spi_port_control_config_bench;
   import spi_port_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [2:0] addr_i = 3'h0;
   logic [7:0] wdata_i = 8'h00;
   logic we_i = 1'b0;
   logic re_i = 1'b0;
   logic tmr_tick_i = 1'b0;
   logic sel_n_i = 1'b1;
   logic start = 1'b0;
   logic pol = 1'b0;
   logic re_d = 1'b0;
   logic [7:0] ftx = 8'h00;
   logic [7:0] rdata_o;
   logic sck_o, sck_oe_n_o, sdo_o, sdo_oe_n_o, irq_o, sck_pin, sdi_pin, far_busy;
   logic [7:0] far_rx;
   logic [7:0] exp_q[$];
   int bad_count = 0;
   int tests_run = 0;
   int tick_cnt = 0;
   int half_tab[4] = '{int'(HALF_FAST), int'(HALF_MID), int'(HALF_SLOW), 6};

   spi_port_control_config dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
      .re_i(re_i), .rdata_o(rdata_o), .tmr_tick_i(tmr_tick_i), .sck_i(sck_pin), .sck_o(sck_o),
      .sck_oe_n_o(sck_oe_n_o), .sdi_i(sdi_pin), .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o), .sel_n_i(sel_n_i),
      .irq_o(irq_o));
   spi_far_model far (.clk_i(clk_i), .pol_i(pol), .start_i(start), .tx_i(ftx), .sck_i(sck_o),
      .sck_oe_n_i(sck_oe_n_o), .sdo_i(sdo_o), .sdo_oe_n_i(sdo_oe_n_o), .sck_pin_o(sck_pin), .sdi_o(sdi_pin),
      .rx_o(far_rx), .busy_o(far_busy));

   // Core clock of 4 ns.
   always #2 clk_i = ~clk_i;

   // Timer tick every six cycles, so a timer-clocked master has a half period of six.
   always @(posedge clk_i) begin
      tick_cnt <= (tick_cnt == 5) ? 0 : tick_cnt + 1;
      tmr_tick_i <= (tick_cnt == 5);
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      tests_run++;
      if (seen !== want) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic s);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      we_i <= 1'b1;
      start <= s;
      @(posedge clk_i);
      we_i <= 1'b0;
      start <= 1'b0;
   endtask

   // A read notes its expected value; the watcher below compares it when the data stand.
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk_i);
      addr_i <= a;
      re_i <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk_i);
      re_i <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so they are taken at the edge closing that cycle.
   always @(posedge clk_i) begin
      if (re_d) chk(rdata_o, exp_q.pop_front());
      re_d <= re_i;
   end

   task automatic wait_irq();
      int n;
      n = 0;
      while (irq_o !== 1'b1) begin
         @(negedge clk_i);
         n++;
         if (n > 3000) begin
            bad_count++;
            end_of_test();
         end
      end
   endtask

   // Counts the cycles between two changes of the driven clock.
   task automatic half_of(output int h);
      logic s;
      h = 0;
      for (int k = 0; k < 2; k++) begin
         s = sck_o;
         h = 0;
         while (sck_o === s && h < 200) begin
            @(negedge clk_i);
            h++;
         end
         if (h >= 200) begin
            bad_count++;
            end_of_test();
         end
      end
   endtask

   initial begin
      logic [7:0] tx;
      logic [7:0] prx;
      logic [3:0] md;
      logic p;
      int h;
      void'($urandom(55113));
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(OFS_CTL, CTL_RESET);
      rd(OFS_STAT, 8'h00);
      rd(OFS_EVT, 8'h00);
      wr(3'h7, 8'hFF, 1'b0);
      rd(3'h7, 8'h00);
      wr(OFS_MASK, 8'h01, 1'b0);
      rd(OFS_MASK, 8'h01);
      $display("test registers done");
      for (int m = 0; m < 4; m++) begin
         @(posedge clk_i);
         p = m[0];
         md = 4'(m);
         tx = 8'($urandom);
         prx = 8'($urandom);
         pol <= p;
         ftx <= prx;
         wr(OFS_CTL, 8'h00, 1'b0);
         wr(OFS_CTL, {3'b001, p, md}, 1'b0);
         // The pin drivers follow the control register one cycle after it is written.
         repeat (2) @(negedge clk_i);
         chk(8'(sck_o), 8'(p));
         chk(8'(sck_oe_n_o), 8'h00);
         wr(OFS_BUF, tx, 1'b1);
         wr(OFS_BUF, ~tx, 1'b0);
         half_of(h);
         chk(8'(h), 8'(half_tab[m]));
         wait_irq();
         rd(OFS_EVT, 8'h03);
         rd(OFS_CTL, {3'b101, p, md});
         rd(OFS_STAT, 8'h01);
         rd(OFS_BUF, prx);
         rd(OFS_STAT, 8'h00);
         repeat (3) @(negedge clk_i);
         chk(8'(irq_o), 8'h00);
         chk(8'(sck_o), 8'(p));
         chk(far_rx, tx);
         $display("test master mode %0d done", m);
      end
      for (int k = 0; k < 3; k++) begin
         @(posedge clk_i);
         p = k[0];
         md = (k == 0) ? MODE_S_FREE : MODE_S_SEL;
         tx = 8'($urandom);
         prx = 8'($urandom);
         pol <= p;
         ftx <= prx;
         sel_n_i <= (k != 2);
         wr(OFS_CTL, 8'h00, 1'b0);
         wr(OFS_CTL, {3'b001, p, md}, 1'b0);
         @(negedge clk_i);
         chk(8'(sck_oe_n_o), 8'h01);
         wr(OFS_BUF, tx, 1'b1);
         repeat (40) @(negedge clk_i);
         chk(8'(sdo_oe_n_o), 8'(k == 1));
         if (k == 1) begin
            for (int w = 0; far_busy === 1'b1; w++) begin
               @(negedge clk_i);
               if (w > 300) begin
                  bad_count++;
                  end_of_test();
               end
            end
            repeat (6) @(negedge clk_i);
            rd(OFS_STAT, 8'h00);
            rd(OFS_EVT, 8'h00);
         end else begin
            wait_irq();
            chk(far_rx, tx);
            rd(OFS_BUF, prx);
            rd(OFS_EVT, 8'h01);
         end
         $display("test slave case %0d done", k);
      end
      repeat (4) @(posedge clk_i);
      end_of_test();
   end
endmodule
